//--- shared/idpei_defs.svh
/*
 * Constants of the ID pin event block: register addresses, field positions,
 * masks, reset values and conversion timing.
 * Assumes a 10 MHz register clock and is included by bare name.
 */
`ifndef IDPEI_DEFS_SVH
`define IDPEI_DEFS_SVH

// Register addresses
`define IDPEI_A_EN_WR   8'h1D
`define IDPEI_A_EN_SET  8'h1E
`define IDPEI_A_EN_CLR  8'h1F
`define IDPEI_A_STAT    8'h20
`define IDPEI_A_LAT     8'h21
`define IDPEI_A_VEN_WR  8'h36
`define IDPEI_A_VEN_SET 8'h37
`define IDPEI_A_VEN_CLR 8'h38
`define IDPEI_A_IMM_TOP 8'h3F

// Writable bits
`define IDPEI_EN_MASK   8'h23
`define IDPEI_VEN_MASK  8'h70

// Field positions
`define IDPEI_B_RISE    0
`define IDPEI_B_FALL    1
`define IDPEI_B_RIRQ    5
`define IDPEI_B_VGO     4
`define IDPEI_B_VIRQ    6
`define IDPEI_B_ID      0
`define IDPEI_B_SDONE   6
`define IDPEI_B_SCODE   3
`define IDPEI_B_VDONE   3
`define IDPEI_B_LID     0
`define IDPEI_B_LCONV   3

// Reset values
`define IDPEI_RST       8'h00
`define IDPEI_OFF       1'h0
`define IDPEI_ON        1'h1
`define IDPEI_CODE_RST  3'h0

// Conversion timing
`define IDPEI_CONV_NS   282000
`define IDPEI_CLK_NS    100
`define IDPEI_CONV_CYC  (`IDPEI_CONV_NS / `IDPEI_CLK_NS)
`define IDPEI_CNT_W     12

`endif

//--- shared/idpei_pkg.sv
/*
 * Types of the ID pin event block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package idpei_pkg;

    typedef enum logic {IDPEI_IDLE, IDPEI_BUSY} idpei_conv_state_type;

    typedef logic [7:0] idpei_byte_type;

endpackage

//--- verilog/idpei_conv.sv
/*
 * Resistor conversion timer: runs a fixed-length conversion after a start
 * pulse and captures the resistor code at its end.
 * Assumes the code pins come from the analogue converter, asynchronous to clk.
 */
`timescale 1ns/1ns
`include "idpei_defs.svh"

module idpei_conv
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       start,
    output logic            finish,
    // Resistor code
    input  wire logic [2:0] code_pin,
    output logic [2:0]      code
);
    import idpei_pkg::*;

    localparam logic [`IDPEI_CNT_W-1:0] LAST_CNT = `IDPEI_CNT_W'(`IDPEI_CONV_CYC - 1);

    idpei_conv_state_type          state;
    idpei_conv_state_type          next_state;
    logic [`IDPEI_CNT_W-1:0]       cnt;
    logic [2:0]                    code_s1;
    logic [2:0]                    code_s2;
    logic [2:0]                    code_s3;
    logic [2:0]                    code_stable;
    wire                           at_end;

    // Code synchroniser, change taken once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_s1     <= `IDPEI_CODE_RST;
            code_s2     <= `IDPEI_CODE_RST;
            code_s3     <= `IDPEI_CODE_RST;
            code_stable <= `IDPEI_CODE_RST;
        end
        else
        begin
            code_s1 <= code_pin;
            code_s2 <= code_s1;
            code_s3 <= code_s2;
            if (code_s2 == code_s3)
                code_stable <= code_s3;
        end
    end

    assign at_end = (state == IDPEI_BUSY) && (cnt == LAST_CNT);

    always_comb
    begin
        next_state = state;
        unique case (state)
            IDPEI_IDLE: if (start) next_state = IDPEI_BUSY;
            IDPEI_BUSY: if (at_end) next_state = IDPEI_IDLE;
        endcase
    end

    // Fixed conversion length
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state  <= IDPEI_IDLE;
            cnt    <= '0;
            finish <= `IDPEI_OFF;
            code   <= `IDPEI_CODE_RST;
        end
        else
        begin
            state  <= next_state;
            cnt    <= (state == IDPEI_BUSY) ? cnt + 1'b1 : '0;
            finish <= at_end;
            if (at_end)
                code <= code_stable;
        end
    end

    conv_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state == IDPEI_BUSY) |-> (state == IDPEI_BUSY) [*8])
        else $error("conversion ended too early");

    conv_fin_a: assert property (@(posedge clk) disable iff (!rst_n)
        finish |-> $past(cnt) == LAST_CNT)
        else $error("conversion finished at wrong count");

endmodule

//--- verilog/idpei_top.sv
/*
 * ID pin event block: enable, live status and read-clear latch registers,
 * resistor conversion register, and alt_int flag for the next RXCMD byte.
 * Assumes a register access port decoded from ULPI register commands and an
 * RXCMD builder that pulses rxcmd_sent when it sends a byte.
 */
`timescale 1ns/1ns
`include "idpei_defs.svh"

// Behaviour
// - Enable at three addresses: write, set, clear
// - Enabled open-going ID change raises alt_int
// - Enabled closing ID change raises alt_int
// - Unused kit and D+ bits read zero
// - Conversion interrupt enable ORed with vendor enable
// - Status read-only, bit 0 live open ID
// - Status bits 5:3 hold resistor code
// - Done flag set after 282 us conversion
// - Only vendor register read clears done
// - Latch read-only, cleared by reading it
// - Latch bit 0 on enabled ID change
// - Latch bit 3 on done rising, enabled
// - Immediate registers reachable by extended address
// - Go bit starts conversion, clears at end
module idpei_top
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Register access
    input  wire logic                reg_ext,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire idpei_pkg::idpei_byte_type reg_wdata,
    output idpei_pkg::idpei_byte_type      reg_rdata,
    output logic                     reg_rvalid,
    // Analogue side
    input  wire logic                id_open_pin,
    input  wire logic [2:0]          id_code_pin,
    output logic                     resistor_read_go,
    // RXCMD side
    input  wire logic                rxcmd_sent,
    output logic                     alt_int
);
    import idpei_pkg::*;

    idpei_byte_type  id_event_enable;
    idpei_byte_type  id_event_latch;
    idpei_byte_type  ven_ctrl;
    idpei_byte_type  id_event_status;
    idpei_byte_type  ven_read;
    idpei_byte_type  rd_mux;
    logic            id_s1;
    logic            id_s2;
    logic            id_s3;
    logic            id_open_status;
    logic            resistor_read_done;
    logic [2:0]      id_resistor_code;
    logic            conv_finish;

    // Address decode
    wire [7:0] eff_addr = reg_ext ? reg_addr : {2'h0, reg_addr[5:0]};
    wire       hit_imm  = eff_addr <= `IDPEI_A_IMM_TOP;
    wire       en_wr    = reg_wr && (eff_addr == `IDPEI_A_EN_WR);
    wire       en_set   = reg_wr && (eff_addr == `IDPEI_A_EN_SET);
    wire       en_clr   = reg_wr && (eff_addr == `IDPEI_A_EN_CLR);
    wire       ven_wr   = reg_wr && (eff_addr == `IDPEI_A_VEN_WR);
    wire       ven_set  = reg_wr && (eff_addr == `IDPEI_A_VEN_SET);
    wire       ven_clr  = reg_wr && (eff_addr == `IDPEI_A_VEN_CLR);
    wire       rd_en    = (eff_addr >= `IDPEI_A_EN_WR) && (eff_addr <= `IDPEI_A_EN_CLR);
    wire       rd_ven   = (eff_addr >= `IDPEI_A_VEN_WR) && (eff_addr <= `IDPEI_A_VEN_CLR);
    wire       rd_stat  = eff_addr == `IDPEI_A_STAT;
    wire       rd_lat   = eff_addr == `IDPEI_A_LAT;
    wire       lat_rd   = reg_rd && rd_lat;
    wire       ven_rd   = reg_rd && rd_ven;

    // Write, set and clear with unused and reserved bits held at zero
    wire [7:0] en_bits = reg_wdata & `IDPEI_EN_MASK;
    wire [7:0] next_enable = en_wr  ? en_bits :
                             en_set ? (id_event_enable | en_bits) :
                             en_clr ? (id_event_enable & ~en_bits) : id_event_enable;

    wire [7:0] ven_bits = reg_wdata & `IDPEI_VEN_MASK;
    wire [7:0] ven_sw   = ven_wr  ? ven_bits :
                          ven_set ? (ven_ctrl | ven_bits) :
                          ven_clr ? (ven_ctrl & ~ven_bits) : ven_ctrl;
    wire       go_start = (ven_wr | ven_set) && reg_wdata[`IDPEI_B_VGO]
                          && !resistor_read_go;

    // Go bit clears at completion unless software sets it again
    wire [7:0] next_ven = (conv_finish && !go_start)
                          ? (ven_sw & ~(8'h01 << `IDPEI_B_VGO)) : ven_sw;

    // ID change seen once stages two and three agree
    wire id_change = (id_s2 == id_s3) && (id_s3 != id_open_status);
    wire id_rise   = id_change && id_s3;
    wire id_fall   = id_change && !id_s3;

    // Interrupt enable from either register
    wire resistor_read_irq_en = id_event_enable[`IDPEI_B_RIRQ] | ven_ctrl[`IDPEI_B_VIRQ];
    wire done_set  = conv_finish && !resistor_read_done;
    wire lat0_set  = (id_rise && id_event_enable[`IDPEI_B_RISE]) ||
                     (id_fall && id_event_enable[`IDPEI_B_FALL]);
    wire lat3_set  = done_set && resistor_read_irq_en;
    wire any_event = lat0_set || lat3_set;

    // Latch, set wins over read clear
    wire next_lat0 = lat0_set || (id_event_latch[`IDPEI_B_LID] && !lat_rd);
    wire next_lat3 = lat3_set || (id_event_latch[`IDPEI_B_LCONV] && !lat_rd);

    // Done flag, only a vendor register read clears it
    wire next_done = conv_finish || (resistor_read_done && !ven_rd);

    // alt_int held for the next RXCMD byte
    wire next_alt  = any_event || (alt_int && !rxcmd_sent);

    // Status view
    assign id_event_status = {1'h0, resistor_read_done, id_resistor_code, 2'h0, id_open_status};
    assign ven_read = {ven_ctrl[7:4], resistor_read_done, id_resistor_code};

    assign rd_mux = !hit_imm && !reg_ext ? `IDPEI_RST :
                    rd_en   ? id_event_enable :
                    rd_stat ? id_event_status :
                    rd_lat  ? id_event_latch :
                    rd_ven  ? ven_read : `IDPEI_RST;

    // ID pin synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            id_s1          <= `IDPEI_OFF;
            id_s2          <= `IDPEI_OFF;
            id_s3          <= `IDPEI_OFF;
            id_open_status <= `IDPEI_OFF;
        end
        else
        begin
            id_s1 <= id_open_pin;
            id_s2 <= id_s1;
            id_s3 <= id_s2;
            if (id_change)
                id_open_status <= id_s3;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            id_event_enable    <= `IDPEI_RST;
            ven_ctrl           <= `IDPEI_RST;
            id_event_latch     <= `IDPEI_RST;
            resistor_read_done <= `IDPEI_OFF;
            alt_int            <= `IDPEI_OFF;
        end
        else
        begin
            id_event_enable    <= next_enable;
            ven_ctrl           <= next_ven;
            id_event_latch     <= {4'h0, next_lat3, 2'h0, next_lat0};
            resistor_read_done <= next_done;
            alt_int            <= next_alt;
        end
    end

    // Read port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= `IDPEI_RST;
            reg_rvalid <= `IDPEI_OFF;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // Conversion request line
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            resistor_read_go <= `IDPEI_OFF;
        else
            resistor_read_go <= next_ven[`IDPEI_B_VGO];
    end

    idpei_conv u_conv
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (go_start),
        .finish   (conv_finish),
        .code_pin (id_code_pin),
        .code     (id_resistor_code)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    en_reserved_a: assert property ((id_event_enable & ~`IDPEI_EN_MASK) == `IDPEI_RST)
        else $error("enable reserved bits set");

    en_setor_a: assert property (en_set |=>
        id_event_enable == ($past(id_event_enable) | ($past(reg_wdata) & `IDPEI_EN_MASK)))
        else $error("enable set access wrong");

    en_clear_a: assert property (en_clr |=>
        (id_event_enable & $past(reg_wdata)) == `IDPEI_RST)
        else $error("enable clear access wrong");

    rise_latch_a: assert property (id_rise && id_event_enable[`IDPEI_B_RISE]
        |=> id_event_latch[`IDPEI_B_LID] && alt_int)
        else $error("rise event not latched");

    fall_alt_a: assert property (id_fall && id_event_enable[`IDPEI_B_FALL] |=> alt_int)
        else $error("fall event gave no alt_int");

    latch_clear_a: assert property (lat_rd && !any_event |=> id_event_latch == `IDPEI_RST)
        else $error("latch not cleared by read");

    status_keep_a: assert property (reg_rd && rd_stat && resistor_read_done
        |=> resistor_read_done)
        else $error("status read cleared done");

    vendor_clear_a: assert property (ven_rd && !conv_finish |=> !resistor_read_done)
        else $error("vendor read kept done");

    done_latch_a: assert property (done_set && resistor_read_irq_en
        |=> id_event_latch[`IDPEI_B_LCONV] ##0 resistor_read_done)
        else $error("conversion event not latched");

    status_read_a: assert property (reg_rd && rd_stat
        |=> reg_rvalid && reg_rdata[`IDPEI_B_ID] == $past(id_open_status))
        else $error("status read shows wrong ID state");

    alt_quiet_a: assert property (rxcmd_sent && !any_event |=> !alt_int)
        else $error("alt_int repeated without event");

    go_clear_a: assert property (conv_finish && !go_start |=> !resistor_read_go)
        else $error("go bit not cleared at end");

    rise_c: cover property (id_rise && id_event_enable[`IDPEI_B_RISE] ##[1:4] rxcmd_sent);
    // Cycles since the last start, for the conversion cover
    logic [`IDPEI_CNT_W-1:0] conv_age;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_age <= '0;
        else if (go_start)
            conv_age <= '0;
        else if (resistor_read_go)
            conv_age <= conv_age + 1'b1;
    end

    conv_c: cover property (conv_finish && (conv_age <= `IDPEI_CONV_CYC));
    clear_c: cover property (lat_rd && id_event_latch != `IDPEI_RST);

endmodule

//--- verif/idpei_link.sv
/*
 * Link controller model: register accesses and RXCMD pulses.
 * Assumes the bench calls its tasks after reset.
 */
`timescale 1ns/1ns

module idpei_link
(
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            reg_ext,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    // RXCMD side
    output logic            rxcmd_sent
);
    initial
    begin
        {reg_ext, reg_wr, reg_rd, rxcmd_sent} = 4'h0;
        reg_addr  = 8'hFF;
        reg_wdata = 8'hA5;
    end

    // ID pull-up taken as set before ID use
    // One access, immediate or extended address
    task acc(input logic ext, input logic [7:0] a, input logic wr, input logic [7:0] d,
             output logic [7:0] q, output logic ok);
        @(posedge clk);
        #10;
        reg_ext   = ext;
        reg_addr  = a;
        reg_wr    = wr;
        reg_rd    = !wr;
        reg_wdata = d;
        @(posedge clk);
        #10;
        q         = reg_rdata;
        ok        = reg_rvalid;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // RXCMD byte with alt_int sent
    task rxcmd();
        @(posedge clk);
        #10;
        rxcmd_sent = 1'b1;
        @(posedge clk);
        #10;
        rxcmd_sent = 1'b0;
    endtask
endmodule

//--- verif/id_pin_event_interrupts_test.sv
/*
 * Self-checking bench of the ID pin event block.
 * Assumes the link model idpei_link and a 10 MHz clock.
 */
`timescale 1ns/1ns
`include "idpei_defs.svh"

module id_pin_event_interrupts_test;
    import idpei_pkg::*;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic           reg_ext, reg_wr, reg_rd, reg_rvalid, rxcmd_sent;
    logic [7:0]     reg_addr;
    idpei_byte_type reg_wdata, reg_rdata;
    logic           id_open_pin = 1'b0;
    logic [2:0]     id_code_pin = 3'h0;
    logic           resistor_read_go, alt_int;
    integer         seed = 35703;
    integer         n_errors = 0;
    integer         total_checks = 0;
    integer         i, k, c;
    logic [7:0]     en, q, d, a;
    logic [2:0]     code;

    always #50 clk = ~clk;

    idpei_top idpei_top_i (.clk, .rst_n, .reg_ext, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .id_open_pin, .id_code_pin, .resistor_read_go, .rxcmd_sent, .alt_int);
    idpei_link idpei_link_i (.clk, .reg_ext, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .rxcmd_sent);

    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task rw(input logic fx, input logic [7:0] ad, input logic wr, input logic [7:0] dd);
        logic ok;
        logic x;
        x = fx | 1'($random(seed));
        idpei_link_i.acc(x, x ? ad : {2'($random(seed)), ad[5:0]}, wr, dd, q, ok);
        if (!wr)
            chk("rvalid", 8'h01, {7'h0, ok});
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function logic [7:0] en_next(input logic [7:0] ad, o, v);
        case (ad)
            8'h1D:   return v & `IDPEI_EN_MASK;
            8'h1E:   return (o | v) & `IDPEI_EN_MASK;
            default: return o & ~v;
        endcase
    endfunction

    function logic [7:0] stat(input logic dn, input logic [2:0] cd, input logic p);
        return {1'b0, dn, cd, 2'b00, p};
    endfunction

    initial
    begin
        repeat (6) @(posedge clk);
        #10;
        rst_n = 1'b1;
        for (i = 0; i < 5; i++)
        begin
            rw(0, 8'(i) + 8'h1D, 0, 0);
            chk("reset_val", 8'h00, q);
        end
        chk("go_alt", 8'h00, {6'h0, resistor_read_go, alt_int});
        $display("test reset done");
        // Write, set, clear with random data
        en = 8'h00;
        for (i = 0; i < 60; i++)
        begin
            a = 8'h1D + 8'($unsigned($random(seed)) % 3);
            d = $random(seed);
            rw(0, a, 1, d);
            en = en_next(a, en, d);
            rw(0, 8'(i % 3) + 8'h1D, 0, 0);
            chk("enable", en, q);
        end
        rw(0, 8'h20, 1, 8'hFF);
        rw(0, 8'h21, 1, 8'hFF);
        rw(1, 8'h5D, 1, 8'hFF);
        rw(0, 8'h1D, 0, 0);
        chk("ext_alias", en, q);
        rw(0, 8'h20, 0, 0);
        chk("status_ro", 8'h00, q);
        rw(0, 8'h21, 0, 0);
        chk("latch_ro", 8'h00, q);
        rw(1, 8'h80, 0, 0);
        chk("unmapped", 8'h00, q);
        $display("test registers done");
        // Rise and fall under each enable pair
        for (k = 0; k < 4; k++)
        begin
            en = {6'h0, 2'(k)};
            rw(0, 8'h1D, 1, en);
            for (i = 0; i < 2; i++)
            begin
                id_open_pin = !id_open_pin;
                cyc(8);
                chk("alt_int", {7'h0, en[i]}, {7'h0, alt_int});
                rw(0, 8'h20, 0, 0);
                chk("status", stat(0, 3'h0, id_open_pin), q);
                rw(0, 8'h21, 0, 0);
                chk("latch", {7'h0, en[i]}, q);
                rw(0, 8'h21, 0, 0);
                chk("latch_clr", 8'h00, q);
                idpei_link_i.rxcmd();
                cyc(3);
                chk("alt_clr", 8'h00, {7'h0, alt_int});
            end
        end
        $display("test id events done");
        // Conversions: block enable, vendor enable, none
        for (k = 0; k < 3; k++)
        begin
            code = $random(seed);
            id_code_pin = code;
            rw(0, 8'h1D, 1, k == 0 ? 8'h20 : 8'h00);
            if (k == 2)
                rw(0, 8'h38, 1, 8'h40);
            rw(0, k > 0 ? 8'h37 : 8'h36, 1, k == 1 ? 8'h50 : 8'h10);
            cyc(1);
            chk("go", 8'h01, {7'h0, resistor_read_go});
            cyc(2810);
            rw(0, 8'h20, 0, 0);
            chk("early", 8'h00, q & 8'h40);
            c = 0;
            while (resistor_read_go && c < 20)
            begin
                cyc(1);
                c++;
            end
            chk("conv_len", 8'h01, {7'h0, c > 4 && c < 10});
            rw(0, 8'h20, 0, 0);
            chk("done", stat(1, code, 0), q);
            rw(0, 8'h20, 0, 0);
            chk("done_kept", stat(1, code, 0), q);
            rw(0, 8'h21, 0, 0);
            chk("latch_conv", k < 2 ? 8'h08 : 8'h00, q);
            chk("alt_conv", {7'h0, k < 2}, {7'h0, alt_int});
            idpei_link_i.rxcmd();
            rw(0, 8'h36 + 8'(k), 0, 0);
            chk("vendor", {1'b0, k == 1, 2'b00, 1'b1, code}, q);
            rw(0, 8'h20, 0, 0);
            chk("done_clr", stat(0, code, 0), q);
        end
        $display("test conversion done");
        final_report();
    end

    initial
    begin
        #3000000;
        n_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        final_report();
    end
endmodule
